// File: pkg/power_mode_pkg.sv
// Shared constants, types and register map of the power mode supervisor
package power_mode_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus widths and register map
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  CTRL_ADDR     = 8'h00;
  localparam logic [7:0]  STATUS_ADDR   = 8'h04;
  localparam logic [7:0]  MASK_ADDR     = 8'h08;
  localparam logic [7:0]  STATE_ADDR    = 8'h0c;
  localparam logic [7:0]  BACKUP_BASE   = 8'h10;
  localparam int          BACKUP_WORDS  = 4;
  localparam int          BACKUP_IDX_W  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Control register, bit 5 downward
  typedef struct packed {
    logic stop_lp;      // bit 5: low power regulator during Stop
    logic standby_sel;  // bit 4: deep wait goes to Standby, else Stop
    logic deep;         // bit 3: wait enters Stop or Standby, else Sleep
    logic fall_sel;     // bit 2: event on supply falling below threshold
    logic rise_sel;     // bit 1: event on supply rising above threshold
    logic monitor_en;   // bit 0: supply threshold monitor on
  } ctrl_t;
  localparam int          CTRL_W        = 6;
  localparam logic [5:0]  CTRL_RESET    = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Status and mask layout
  localparam int          STATUS_W      = 4;
  localparam int          ST_FALL       = 0;
  localparam int          ST_RISE       = 1;
  localparam int          ST_STOP_WAKE  = 2;
  localparam int          ST_STBY_WAKE  = 3;
  localparam logic [3:0]  STATUS_RESET  = 4'h0;
  localparam logic [3:0]  MASK_RESET    = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // State register layout
  localparam int          SR_STATE_LSB  = 0;
  localparam int          SR_REG_LSB    = 4;
  localparam int          SR_BELOW_BIT  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          OSC_START_NS  = 2000;
  localparam int          REG_SETTLE_NS = 500;
  localparam int          OSC_START_CYCLES  = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          REG_SETTLE_CYCLES = (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    REG_MAIN,
    REG_LOW_POWER,
    REG_OFF
  } regulator_mode_t;

  typedef enum logic [2:0] {
    PS_RUN,
    PS_SLEEP,
    PS_STOP_GATE,
    PS_STOP,
    PS_STOP_WAKE,
    PS_STBY_GATE,
    PS_STANDBY,
    PS_STBY_WAKE
  } power_state_t;

  typedef struct packed {
    logic cpu;   // CPU clock
    logic core;  // peripheral clocks of the core domain
    logic pll;
    logic rc;    // internal_rc_oscillator enable
    logic xtal;  // external_crystal_oscillator enable
  } clock_ctl_t;
  localparam logic [4:0]  CLOCKS_ALL_ON = 5'h1f;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

endpackage

// File: core/supply_sense.sv
// Pin synchronisers and threshold crossing detection for the supply monitor
`timescale 1ns/1ns
module supply_sense (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic supply_below_reset,
  input  wire logic supply_below_threshold,
  input  wire logic wakeup_pin,
  input  wire logic monitor_en,
  output logic      below_reset,
  output logic      below_threshold,
  output logic      fall_pulse,
  output logic      rise_pulse,
  output logic      wake_rise
);

  logic [2:0] pins;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       prev_below;
  logic       prev_wake;

  assign pins = {wakeup_pin, supply_below_threshold, supply_below_reset};

  ////////////////////////////////////////////////////////////////////////////
  // Two stages per pin; only the second stage is looked at
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
      end else begin
        sync1[i] <= pins[i];
        sync2[i] <= sync1[i];
      end
    end
  end

  assign below_reset     = sync2[0];
  assign below_threshold = sync2[1];

  ////////////////////////////////////////////////////////////////////////////
  // Crossing detection; tracking while off avoids a false edge on enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_below <= 1'b0;
      prev_wake  <= 1'b0;
      fall_pulse <= 1'b0;
      rise_pulse <= 1'b0;
      wake_rise  <= 1'b0;
    end else begin
      prev_below <= sync2[1];
      prev_wake  <= sync2[2];
      fall_pulse <= monitor_en & sync2[1] & ~prev_below;
      rise_pulse <= monitor_en & ~sync2[1] & prev_below;
      wake_rise  <= sync2[2] & ~prev_wake;
    end
  end

endmodule

// File: core/backup_regs.sv
// Backup domain register words, reset only by the backup domain reset
`timescale 1ns/1ns
module backup_regs #(
  parameter int WORDS = power_mode_pkg::BACKUP_WORDS,
  parameter int IDX_W = power_mode_pkg::BACKUP_IDX_W
) (
  input  wire logic                              clk,
  input  wire logic                              backup_rst,
  input  wire logic                              wr,
  input  wire logic [IDX_W-1:0]                  idx,
  input  wire logic [power_mode_pkg::DATA_W-1:0] wdata,
  output logic      [power_mode_pkg::DATA_W-1:0] rword
);
  import power_mode_pkg::*;

  logic [DATA_W-1:0] mem [WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // Main reset deliberately absent so settings survive it
  always_ff @(posedge clk or posedge backup_rst) begin
    if (backup_rst) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= '0;
      end
    end else if (wr) begin
      mem[idx] <= wdata;
    end
  end

  assign rword = mem[idx];

endmodule

// File: core/power_mode_supervisor.sv
// Power supervisor: reset hold, supply monitor, regulator and low-power modes
//
// Contract
// - Hold core reset while the supply is below the reset threshold.
// - Monitor raises events on falling, rising, or both threshold crossings.
// - Monitor stays inactive until software sets its enable bit.
// - Main regulator in Run, main or low-power regulator in Stop per stop_lp, off in Standby.
// - Standby makes regulator output high impedance and unpowers core, losing state.
// - Regulator enabled out of system reset (backup reset leaves it alone), disabled only in Standby.
// - Sleep halts only the CPU clock; peripherals keep running.
// - Any peripheral interrupt or event wakes the CPU from Sleep.
// - Stop gates core clocks and disables PLL, RC and crystal oscillators.
// - Stop keeps all register and memory contents intact.
// - Stop runs regulator in main or low-power mode per configuration.
// - Backup registers are not cleared by the main reset.
`timescale 1ns/1ns
module power_mode_supervisor #(
  parameter int OSC_CYCLES    = power_mode_pkg::OSC_START_CYCLES,
  parameter int SETTLE_CYCLES = power_mode_pkg::REG_SETTLE_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              backup_rst,
  input  wire power_mode_pkg::bus_req_t          bus,
  output logic      [power_mode_pkg::DATA_W-1:0] rdata,
  input  wire logic                              supply_below_reset,
  input  wire logic                              supply_below_threshold,
  input  wire logic                              wakeup_pin,
  input  wire logic                              cpu_wait,
  input  wire logic                              wake_irq,
  input  wire logic                              wake_event,
  output logic                                   power_down_reset,
  output power_mode_pkg::clock_ctl_t             clocks,
  output power_mode_pkg::regulator_mode_t        regulator_mode,
  output logic                                   regulator_hiz,
  output logic                                   core_power_en,
  output logic                                   monitor_enable,
  output logic                                   irq
);
  import power_mode_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  power_state_t          state;
  power_state_t          next_state;
  ctrl_t                 ctrl;
  logic [STATUS_W-1:0]   status;
  logic [STATUS_W-1:0]   mask;
  logic [STATUS_W-1:0]   status_set;
  logic [STATUS_W-1:0]   status_clr;
  logic [CNT_W-1:0]      wait_cnt;
  logic                  below_reset;
  logic                  below_threshold;
  logic                  fall_pulse;
  logic                  rise_pulse;
  logic                  wake_rise;
  logic                  wake_any;
  logic                  wr_ctrl;
  logic                  wr_status;
  logic                  wr_mask;
  logic                  wr_backup;
  logic [DATA_W-1:0]     backup_word;
  logic [DATA_W-1:0]     read_value;

  function automatic logic backup_hit(input logic [ADDR_W-1:0] a);
    backup_hit = (a >= BACKUP_BASE) && (a < BACKUP_BASE + 8'(4 * BACKUP_WORDS)) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [BACKUP_IDX_W-1:0] backup_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off          = a - BACKUP_BASE;
    backup_index = off[BACKUP_IDX_W+1:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin sense and crossing events
  supply_sense u_sense (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .supply_below_reset     (supply_below_reset),
    .supply_below_threshold (supply_below_threshold),
    .wakeup_pin             (wakeup_pin),
    .monitor_en             (ctrl.monitor_en),
    .below_reset            (below_reset),
    .below_threshold        (below_threshold),
    .fall_pulse             (fall_pulse),
    .rise_pulse             (rise_pulse),
    .wake_rise              (wake_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Backup words
  backup_regs u_backup (
    .clk        (clk),
    .backup_rst (backup_rst),
    .wr         (wr_backup),
    .idx        (backup_index(bus.addr)),
    .wdata      (bus.wdata),
    .rword      (backup_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  always_comb begin
    wr_ctrl   = 1'b0;
    wr_status = 1'b0;
    wr_mask   = 1'b0;
    wr_backup = 1'b0;
    if (bus.wr && bus.addr == CTRL_ADDR) begin
      wr_ctrl = 1'b1;
    end else if (bus.wr && bus.addr == STATUS_ADDR) begin
      wr_status = 1'b1;
    end else if (bus.wr && bus.addr == MASK_ADDR) begin
      wr_mask = 1'b1;
    end else if (bus.wr && backup_hit(bus.addr)) begin
      wr_backup = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  assign wake_any = wake_irq | wake_event;

  always_comb begin
    next_state = state;
    case (state)
      PS_RUN: begin
        if (cpu_wait && !ctrl.deep) begin
          next_state = PS_SLEEP;
        end else if (cpu_wait && ctrl.standby_sel) begin
          next_state = PS_STBY_GATE;
        end else if (cpu_wait) begin
          next_state = PS_STOP_GATE;
        end
      end
      PS_SLEEP: begin
        if (wake_any) begin
          next_state = PS_RUN;
        end
      end
      PS_STOP_GATE: begin
        next_state = PS_STOP;
      end
      PS_STOP: begin
        if (wake_any) begin
          next_state = PS_STOP_WAKE;
        end
      end
      PS_STOP_WAKE: begin
        if (wait_cnt == '0) begin
          next_state = PS_RUN;
        end
      end
      PS_STBY_GATE: begin
        next_state = PS_STANDBY;
      end
      PS_STANDBY: begin
        if (wake_rise) begin
          next_state = PS_STBY_WAKE;
        end
      end
      PS_STBY_WAKE: begin
        if (wait_cnt == '0) begin
          next_state = PS_RUN;
        end
      end
      default: begin
        next_state = PS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= PS_RUN;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake settle timer: oscillators restart before clocks return
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_cnt <= '0;
    end else if (state != PS_STOP_WAKE && next_state == PS_STOP_WAKE) begin
      wait_cnt <= CNT_W'(OSC_CYCLES - 1);
    end else if (state != PS_STBY_WAKE && next_state == PS_STBY_WAKE) begin
      wait_cnt <= CNT_W'(SETTLE_CYCLES - 1);
    end else if (wait_cnt != '0) begin
      wait_cnt <= wait_cnt - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gating, taken from the next state so outputs track it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clocks <= CLOCKS_ALL_ON;
    end else begin
      case (next_state)
        PS_RUN:       clocks <= CLOCKS_ALL_ON;
        PS_SLEEP:     clocks <= '{cpu: 1'b0, core: 1'b1, pll: 1'b1, rc: 1'b1, xtal: 1'b1};
        PS_STOP_GATE: clocks <= '{cpu: 1'b0, core: 1'b0, pll: 1'b1, rc: 1'b1, xtal: 1'b1};
        PS_STBY_GATE: clocks <= '{cpu: 1'b0, core: 1'b0, pll: 1'b1, rc: 1'b1, xtal: 1'b1};
        PS_STOP:      clocks <= '0;
        PS_STANDBY:   clocks <= '0;
        default:      clocks <= '{cpu: 1'b0, core: 1'b0, pll: 1'b1, rc: 1'b1, xtal: 1'b1};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulator and core power
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regulator_mode <= REG_MAIN;
      regulator_hiz  <= 1'b0;
      core_power_en  <= 1'b1;
    end else begin
      if (next_state == PS_STOP && ctrl.stop_lp) begin
        regulator_mode <= REG_LOW_POWER;
      end else if (next_state == PS_STANDBY) begin
        regulator_mode <= REG_OFF;
      end else begin
        regulator_mode <= REG_MAIN;
      end
      regulator_hiz <= (next_state == PS_STANDBY);
      core_power_en <= (next_state != PS_STANDBY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core reset hold: low supply, unpowered core, and the way back out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_down_reset <= 1'b1;
    end else begin
      power_down_reset <= below_reset | (next_state == PS_STANDBY) | (next_state == PS_STBY_WAKE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and mask; Standby wipes them, Stop leaves them alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET;
    end else if (next_state == PS_STANDBY) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= bus.wdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask <= MASK_RESET;
    end else if (next_state == PS_STANDBY) begin
      mask <= MASK_RESET;
    end else if (wr_mask) begin
      mask <= bus.wdata[STATUS_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      monitor_enable <= 1'b0;
    end else begin
      monitor_enable <= ctrl.monitor_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status; a set in the clearing cycle wins
  always_comb begin
    status_set               = '0;
    status_set[ST_FALL]      = fall_pulse & ctrl.fall_sel;
    status_set[ST_RISE]      = rise_pulse & ctrl.rise_sel;
    status_set[ST_STOP_WAKE] = (state == PS_STOP_WAKE) && (next_state == PS_RUN);
    status_set[ST_STBY_WAKE] = (state == PS_STBY_WAKE) && (next_state == PS_RUN);
    status_clr               = wr_status ? bus.wdata[STATUS_W-1:0] : '0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status <= STATUS_RESET;
    end else if (next_state == PS_STANDBY) begin
      status <= STATUS_RESET;
    end else begin
      status <= (status & ~status_clr) | status_set;
    end
  end

  // One cycle behind status; keeps the output a plain flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, data valid only in the cycle after the strobe
  always_comb begin
    read_value = '0;
    if (bus.addr == CTRL_ADDR) begin
      read_value[CTRL_W-1:0] = ctrl;
    end else if (bus.addr == STATUS_ADDR) begin
      read_value[STATUS_W-1:0] = status;
    end else if (bus.addr == MASK_ADDR) begin
      read_value[STATUS_W-1:0] = mask;
    end else if (bus.addr == STATE_ADDR) begin
      read_value[SR_STATE_LSB +: 3] = state;
      read_value[SR_REG_LSB +: 2]   = regulator_mode;
      read_value[SR_BELOW_BIT]      = below_threshold;
    end else if (backup_hit(bus.addr)) begin
      read_value = backup_word;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (bus.rd) begin
      rdata <= read_value;
    end else begin
      rdata <= '0;
    end
  end

endmodule

// File: verif/power_mode_chk.sv
// Port assertions of the power mode supervisor
`timescale 1ns/1ns
module power_mode_chk (
  input logic                            clk,
  input logic                            sys_rst,
  input power_mode_pkg::bus_req_t        bus,
  input logic                            supply_below_reset,
  input logic                            wake_irq,
  input logic                            wake_event,
  input logic                            power_down_reset,
  input power_mode_pkg::clock_ctl_t      clocks,
  input power_mode_pkg::regulator_mode_t regulator_mode,
  input logic                            regulator_hiz,
  input logic                            core_power_en,
  input logic                            monitor_enable,
  input logic                            irq
);
  import power_mode_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Entry and exit steps of Stop and Standby
  sequence s_gated;
    !clocks.cpu && !clocks.core && clocks.pll;
  endsequence
  sequence s_all_off;
    clocks == 5'h00;
  endsequence
  sequence s_quiet_gate;
    $fell(clocks.core) && !wake_irq && !wake_event;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_reset_hold: assert property (supply_below_reset [*4] |-> power_down_reset)
    else $error("core not held in reset while supply low");
  a_hiz_unpowered: assert property (regulator_hiz |-> regulator_mode == REG_OFF && !core_power_en)
    else $error("high impedance regulator with core powered");
  a_reg_off_only: assert property (regulator_mode == REG_OFF |-> regulator_hiz and s_all_off)
    else $error("regulator off outside standby");
  a_lp_in_stop: assert property (regulator_mode == REG_LOW_POWER |-> s_all_off)
    else $error("low power regulator while clocks run");
  a_core_keeps_osc: assert property (clocks.core |-> clocks.pll && clocks.rc && clocks.xtal)
    else $error("oscillator off while core clocks run");
  a_stop_entry: assert property (s_quiet_gate |-> s_gated ##1 s_all_off)
    else $error("clock gating order broken");
  a_stop_wake: assert property ($rose(clocks.pll) |-> !clocks.core && regulator_mode == REG_MAIN)
    else $error("wake restarted core before oscillators");
  a_sleep_wake: assert property (clocks == 5'h0f && (wake_irq || wake_event) |-> ##[1:2] clocks == 5'h1f)
    else $error("sleep not left on wake");
  a_mon_follow: assert property (bus.wr && bus.addr == CTRL_ADDR |->
    ##2 monitor_enable == $past(bus.wdata[0], 2))
    else $error("monitor enable does not follow control");
  a_mask_quiet: assert property (bus.wr && bus.addr == MASK_ADDR && bus.wdata[3:0] == 4'h0 |-> ##2 !irq)
    else $error("interrupt with all sources masked");
endmodule
bind power_mode_supervisor power_mode_chk i_power_mode_chk (.*);

// File: verif/power_mode_supervisor_tb.sv
// Self-checking bench of the power mode supervisor
`timescale 1ns/1ns
module power_mode_supervisor_tb;
  import power_mode_pkg::*;
  localparam int OSC = 2;
  localparam int SET = 2;
  logic            clk = 1'b0, sys_rst = 1'b1, backup_rst = 1'b1;
  logic            supply_below_reset = 1'b0, supply_below_threshold = 1'b0;
  logic            wakeup_pin = 1'b0, cpu_wait = 1'b0, wake_irq = 1'b0, wake_event = 1'b0;
  bus_req_t        bus = '0;
  logic [31:0]     rdata, d, c;
  logic [31:0]     bk [4];
  logic            power_down_reset, regulator_hiz, core_power_en, monitor_enable, irq;
  clock_ctl_t      clocks;
  regulator_mode_t regulator_mode;
  int              fail_count = 0, compares = 0, cycles = 0;

  power_mode_supervisor #(.OSC_CYCLES(OSC), .SETTLE_CYCLES(SET)) i_power_mode_supervisor (.*);

  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  task automatic strobe(input logic [2:0] m);
    @(posedge clk);
    {cpu_wait, wake_irq, wake_event} <= m;
    @(posedge clk);
    {cpu_wait, wake_irq, wake_event} <= 3'h0;
  endtask
  // One dip below the threshold and back, past the synchroniser
  task automatic toggle();
    @(posedge clk) supply_below_threshold <= 1'b1;
    cyc(6);
    @(posedge clk) supply_below_threshold <= 1'b0;
    cyc(6);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    d = $urandom(60);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    backup_rst <= 1'b0;
    cyc(2);
    chk(32'(clocks), 32'(CLOCKS_ALL_ON));
    chk({regulator_hiz, core_power_en, 30'(regulator_mode)}, {2'b01, 30'(REG_MAIN)});
    rchk(CTRL_ADDR, 32'h0);
    rchk(8'h40, 32'h0);
    @(posedge clk) supply_below_reset <= 1'b1;
    cyc(5);
    chk(32'(power_down_reset), 32'h1);
    @(posedge clk) supply_below_reset <= 1'b0;
    cyc(5);
    chk(32'(power_down_reset), 32'h0);
    foreach (bk[i]) begin
      bk[i] = $urandom;
      wr(BACKUP_BASE + 8'(4 * i), bk[i]);
    end
    @(posedge clk) sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (bk[i]) rchk(BACKUP_BASE + 8'(4 * i), bk[i]);
    wr(CTRL_ADDR, 32'h6);
    toggle();
    rchk(STATUS_ADDR, 32'h0);
    wr(MASK_ADDR, 32'h3);
    for (int s = 1; s < 4; s++) begin
      // Mode bits ride along at random; they act only on a wait
      c = 32'(1 + 2 * s) | ($urandom & 32'h38);
      wr(CTRL_ADDR, c);
      toggle();
      chk(32'(monitor_enable), 32'h1);
      rchk(STATUS_ADDR, 32'({s[0], s[1]}));
      chk(32'(irq), 32'h1);
      wr(STATUS_ADDR, 32'hf);
      cyc(2);
      chk(32'(irq), 32'h0);
    end
    wr(MASK_ADDR, 32'h0);
    for (int lp = 0; lp < 2; lp++) begin
      wr(CTRL_ADDR, 32'(8 + 32 * lp));
      strobe(3'h4);
      cyc(4);
      chk(32'(clocks), 32'h0);
      chk(32'(regulator_mode), lp ? 32'(REG_LOW_POWER) : 32'(REG_MAIN));
      rchk(STATE_ADDR, 32'(PS_STOP) | 32'(lp ? REG_LOW_POWER : REG_MAIN) << SR_REG_LSB);
      strobe(lp ? 3'h2 : 3'h1);
      cyc(OSC + 4);
      chk(32'(clocks), 32'(CLOCKS_ALL_ON));
      chk(32'(regulator_mode), 32'(REG_MAIN));
      rchk(STATUS_ADDR, 32'h4);
      rchk(CTRL_ADDR, 32'(8 + 32 * lp));
      wr(STATUS_ADDR, 32'h4);
    end
    rchk(BACKUP_BASE, bk[0]);
    wr(CTRL_ADDR, 32'h0);
    for (int w = 1; w < 3; w++) begin
      strobe(3'h4);
      cyc(2);
      chk(32'(clocks), 32'h0f);
      strobe(3'(w));
      cyc(2);
      chk(32'(clocks), 32'(CLOCKS_ALL_ON));
    end
    wr(CTRL_ADDR, 32'h18);
    strobe(3'h4);
    cyc(4);
    chk({regulator_hiz, core_power_en, power_down_reset, 29'(regulator_mode)}, {3'b101, 29'(REG_OFF)});
    @(posedge clk) wakeup_pin <= 1'b1;
    cyc(SET + 8);
    chk({regulator_hiz, core_power_en, power_down_reset, 29'(regulator_mode)}, {3'b010, 29'(REG_MAIN)});
    rchk(STATUS_ADDR, 32'h8);
    rchk(CTRL_ADDR, 32'h0);
    print_verdict();
  end
endmodule
